// ### src/scrs_top.sv
// Strap configuration decoder and reference clock selector
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - After reset each strap is probed to tell ground, power, or a config pin apart.
// - Straps six and seven pick an odd output divide ratio from 1 to 15.
// - The same strap pair enables or disables the lock indicator.
// - With the lock indicator disabled its output is held low.
// - The same strap pair sets the pad mode of the third and fourth outputs.
// - The reference frequency is one of six spot values, tracked within 400 ppm.
// - Either reference may be active, picked manually or automatically.
// - In manual mode a high pick input selects reference B, low selects A.
// - Automatic mode is entered by auto select high with the pick input low.
// - The selected reference alarm is high while the selected reference is dead.
module scrs_top (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        strap_input_six_in,
  input  wire logic        strap_input_seven_in,
  input  wire logic        ref_a_pos_in,
  input  wire logic        ref_a_neg_in,
  input  wire logic        ref_b_pos_in,
  input  wire logic        ref_b_neg_in,
  input  wire logic        manual_ref_pick_in,
  input  wire logic        auto_sel_in,
  input  wire logic        phase_err_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out,
  output logic             irq_out,
  output logic [3:0]       cfg_pin_out,
  output logic             selected_ref_alarm_out,
  output logic             phase_lock_indicator_out,
  output logic [3:0]       odd_div_ratio_out,
  output logic             third_output_cml_out,
  output logic             fourth_output_cml_out,
  output logic             cfg_done_out,
  output logic             ref_b_selected_out,
  output logic [2:0]       ref_freq_code_out
);
  typedef enum logic [0:0] {CFG_PROBE, CFG_RUN} scrs_cfg_e;

  scrs_cfg_e   cfg_state_q;
  logic [1:0]  phase_q;
  logic [7:0]  settle_q;
  logic [2:0]  word6_q;
  logic [2:0]  word7_q;
  logic [2:0]  code6_q;
  logic [2:0]  code7_q;
  logic [2:0]  div_code_q;
  logic        lock_en_q;
  logic        pad_cml_q;
  logic [1:0]  s6_meta_q;
  logic [1:0]  s6_sync_q;
  logic [1:0]  sel_meta_q;
  logic [1:0]  sel_sync_q;
  logic [1:0]  err_sync_q;
  logic        ref_b_q;
  logic        ref_b_d;
  logic        alarm_q;
  logic        lock_ind_q;
  logic [2:0]  freq_q;
  logic [3:0]  irq_stat_q;
  logic [3:0]  irq_stat_d;
  logic [3:0]  irq_mask_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [3:0]  probe_drive;
  logic        act_a;
  logic        act_b;

  // Decode of probe words and the strap pair index
  function automatic logic [2:0] word_to_code(input logic [2:0] w);
    logic [2:0] c;
    c = scrs_pkg::CODE_GND;
    if (w == scrs_pkg::WORD_PWR)
    begin
      c = scrs_pkg::CODE_PWR;
    end
    else if (w != scrs_pkg::WORD_GND && w <= 3'(scrs_pkg::NUM_CFG_PINS))
    begin
      c = scrs_pkg::CODE_PIN_BASE + w - 3'h1;
    end
    return c;
  endfunction

  wire        settle_end = (settle_q == scrs_pkg::SETTLE_CYC);
  wire        probing    = (cfg_state_q == CFG_PROBE);
  wire        sample_now = probing && settle_end;
  wire        last_phase = (phase_q == scrs_pkg::LAST_PHASE);
  wire [2:0]  word6_nx   = {word6_q[1:0], s6_sync_q[0]};
  wire [2:0]  word7_nx   = {word7_q[1:0], s6_sync_q[1]};
  wire [2:0]  code6_nx   = word_to_code(word6_nx);
  wire [2:0]  code7_nx   = word_to_code(word7_nx);
  wire [5:0]  pair_idx   = 6'(code6_nx) * scrs_pkg::STRAP_RADIX + 6'(code7_nx);
  wire        finish_cfg = sample_now && last_phase;

  // Config pins carry the probe word one bit per phase, msb first
  genvar k;
  generate
    for (k = 0; k < scrs_pkg::NUM_CFG_PINS; k++)
    begin : g_probe
      assign probe_drive[k] =
        scrs_pkg::PROBE_PATTERN[k * 3 + 2 - int'(phase_q)];
    end
  endgenerate

  // Pin three doubles as the alarm once configuration has ended
  assign cfg_pin_out = probing ? probe_drive : {alarm_q, 3'h0};

  // Strap probe sequencer
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      cfg_state_q <= CFG_PROBE;
      phase_q     <= 2'h0;
      settle_q    <= 8'h00;
      word6_q     <= 3'h0;
      word7_q     <= 3'h0;
    end
    else if (ce_in && probing)
    begin
      settle_q <= settle_end ? 8'h00 : settle_q + 8'h01;
      if (sample_now)
      begin
        word6_q <= word6_nx;
        word7_q <= word7_nx;
        phase_q <= phase_q + 2'h1;
        if (last_phase)
        begin
          cfg_state_q <= CFG_RUN;
        end
      end
    end
  end

  // Decoded straps latch once and then hold until reset
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      code6_q    <= scrs_pkg::CODE_GND;
      code7_q    <= scrs_pkg::CODE_GND;
      div_code_q <= 3'h0;
      lock_en_q  <= 1'b0;
      pad_cml_q  <= 1'b0;
    end
    else if (ce_in && finish_cfg)
    begin
      code6_q    <= code6_nx;
      code7_q    <= code7_nx;
      div_code_q <= pair_idx[2:0];
      lock_en_q  <= ~pair_idx[scrs_pkg::IDX_LOCK_OFF];
      pad_cml_q  <= pair_idx[scrs_pkg::IDX_PAD_CML];
    end
  end

  // Ratio is always odd: code n gives 2n+1
  assign odd_div_ratio_out     = {div_code_q, 1'b1};
  assign third_output_cml_out  = pad_cml_q;
  assign fourth_output_cml_out = pad_cml_q;
  assign cfg_done_out          = ~probing;

  // Pin synchronisers
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      s6_meta_q  <= 2'h0;
      s6_sync_q  <= 2'h0;
      sel_meta_q <= 2'h0;
      sel_sync_q <= 2'h0;
      err_sync_q <= 2'h0;
    end
    else if (ce_in)
    begin
      s6_meta_q  <= {strap_input_seven_in, strap_input_six_in};
      s6_sync_q  <= s6_meta_q;
      sel_meta_q <= {auto_sel_in, manual_ref_pick_in};
      sel_sync_q <= sel_meta_q;
      err_sync_q <= {err_sync_q[0], phase_err_in};
    end
  end

  scrs_act_mon u_mon_a (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .pos_in     (ref_a_pos_in),
    .neg_in     (ref_a_neg_in),
    .active_out (act_a)
  );

  scrs_act_mon u_mon_b (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .pos_in     (ref_b_pos_in),
    .neg_in     (ref_b_neg_in),
    .active_out (act_b)
  );

  // Reference selection
  wire auto_mode   = sel_sync_q[1] && !sel_sync_q[0];
  wire sel_active  = ref_b_q ? act_b : act_a;
  wire oth_active  = ref_b_q ? act_a : act_b;
  // Swap only toward a live reference, so two dead inputs never ping-pong
  wire auto_swap   = auto_mode && !sel_active && oth_active;
  wire switch_evt  = (ref_b_d != ref_b_q);
  wire alarm_d     = ~(ref_b_d ? act_b : act_a);
  wire alarm_rise  = alarm_d && !alarm_q;

  always_comb
  begin
    ref_b_d = ref_b_q;
    if (auto_mode)
    begin
      ref_b_d = auto_swap ? ~ref_b_q : ref_b_q;
    end
    else
    begin
      ref_b_d = sel_sync_q[0];
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      ref_b_q    <= 1'b0;
      alarm_q    <= 1'b0;
      lock_ind_q <= 1'b0;
    end
    else if (ce_in)
    begin
      ref_b_q    <= ref_b_d;
      alarm_q    <= alarm_d;
      lock_ind_q <= lock_en_q & err_sync_q[1];
    end
  end

  assign ref_b_selected_out       = ref_b_q;
  assign selected_ref_alarm_out   = alarm_q;
  assign phase_lock_indicator_out = lock_ind_q;

  // Register bus decode
  wire hit_ctrl   = (addr_in == scrs_pkg::ADDR_CTRL);
  wire hit_strap  = (addr_in == scrs_pkg::ADDR_STRAP_STAT);
  wire hit_ref    = (addr_in == scrs_pkg::ADDR_REF_STAT);
  wire hit_istat  = (addr_in == scrs_pkg::ADDR_IRQ_STAT);
  wire hit_imask  = (addr_in == scrs_pkg::ADDR_IRQ_MASK);
  wire freq_wr    = wr_in && hit_ctrl;
  // Codes past the six spot frequencies are refused and flagged
  wire freq_ok    = (wdata_in[2:0] < scrs_pkg::FREQ_CODES);
  wire istat_rd   = rd_in && hit_istat;

  wire [3:0] irq_evt;
  assign irq_evt[scrs_pkg::IRQ_CFG_DONE] = finish_cfg;
  assign irq_evt[scrs_pkg::IRQ_SWITCH]   = switch_evt;
  assign irq_evt[scrs_pkg::IRQ_ALARM]    = alarm_rise;
  assign irq_evt[scrs_pkg::IRQ_BAD_FREQ] = freq_wr && !freq_ok;

  // Set beats the clear of a same-cycle read
  assign irq_stat_d = (irq_stat_q & ~{4{istat_rd}}) | irq_evt;

  wire [31:0] strap_word = {20'h00000, code7_q, code6_q, ~probing,
                            pad_cml_q, lock_en_q, div_code_q};
  wire [31:0] ref_word   = {27'h0000000, alarm_q, act_b, act_a,
                            auto_mode, ref_b_q};

  always_comb
  begin
    rdata_d = 32'h00000000;
    unique case (1'b1)
      hit_ctrl:  rdata_d = {29'h00000000, freq_q};
      hit_strap: rdata_d = strap_word;
      hit_ref:   rdata_d = ref_word;
      hit_istat: rdata_d = {28'h0000000, irq_stat_q};
      hit_imask: rdata_d = {28'h0000000, irq_mask_q};
      default:   rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      freq_q     <= scrs_pkg::CTRL_RST;
      irq_mask_q <= scrs_pkg::IRQ_MASK_RST;
      irq_stat_q <= 4'h0;
      rdata_q    <= 32'h00000000;
    end
    else if (ce_in)
    begin
      if (freq_wr && freq_ok)
      begin
        freq_q <= wdata_in[2:0];
      end
      if (wr_in && hit_imask)
      begin
        irq_mask_q <= wdata_in[3:0];
      end
      irq_stat_q <= irq_stat_d;
      rdata_q    <= rd_in ? rdata_d : 32'h00000000;
    end
  end

  assign rdata_out         = rdata_q;
  assign irq_out           = |(irq_stat_q & irq_mask_q);
  assign ref_freq_code_out = freq_q;
endmodule
`default_nettype wire

// ### src/scrs_pkg.sv
// Shared constants for the strap decoder and reference selector
package scrs_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_NS     = 1000;
  localparam int SETTLE_CYC_I  = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACT_WIN_NS    = 2000;
  localparam int ACT_WIN_CYC_I = (ACT_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_CYC  = 8'(SETTLE_CYC_I);
  localparam logic [7:0] ACT_WIN_CYC = 8'(ACT_WIN_CYC_I);

  // Strap probing: three phases, config pin k drives the 3-bit word k+1
  localparam int              NUM_CFG_PINS  = 4;
  localparam logic [1:0]      LAST_PHASE    = 2'h2;
  localparam logic [11:0]     PROBE_PATTERN = 12'h8D1;
  localparam logic [2:0]      WORD_GND      = 3'h0;
  localparam logic [2:0]      WORD_PWR      = 3'h7;
  localparam logic [2:0]      CODE_GND      = 3'h0;
  localparam logic [2:0]      CODE_PWR      = 3'h1;
  localparam logic [2:0]      CODE_PIN_BASE = 3'h2;
  localparam logic [5:0]      STRAP_RADIX   = 6'h06;
  localparam int              IDX_LOCK_OFF  = 3;
  localparam int              IDX_PAD_CML   = 4;

  // Reference frequency codes: 19.44, 38.88, 77.76, 125.00, 155.52, 156.25 MHz
  localparam logic [2:0]      FREQ_CODES    = 3'h6;
  localparam int              TRACK_PPM     = 400;

  // Register map
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_STRAP_STAT = 8'h04;
  localparam logic [7:0]  ADDR_REF_STAT   = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h10;
  localparam logic [2:0]  CTRL_RST        = 3'h0;
  localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;
  localparam int          IRQ_CFG_DONE    = 0;
  localparam int          IRQ_SWITCH      = 1;
  localparam int          IRQ_ALARM       = 2;
  localparam int          IRQ_BAD_FREQ    = 3;
endpackage

// ### src/scrs_act_mon.sv
// Activity monitor for one differential reference input
`timescale 1ns/1ps
`default_nettype none
module scrs_act_mon (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  input  wire logic pos_in,
  input  wire logic neg_in,
  output logic      active_out
);
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] last_q;
  logic [7:0] idle_q;
  logic [2:0] fill_q;
  logic [7:0] idle_d;
  logic       active_q;
  logic       active_d;
  wire        toggle;
  wire        expired;

  // Sampling at 20 MHz aliases fast refs; any toggle counts as life
  // Compare only once last_q holds a real sample, else a dead pin looks live after reset
  assign toggle  = fill_q[2] && |(sync_q ^ last_q);
  assign expired = (idle_q >= scrs_pkg::ACT_WIN_CYC);
  assign idle_d  = toggle ? 8'h00 : (expired ? idle_q : idle_q + 8'h01);
  assign active_d = toggle ? 1'b1 : (expired ? 1'b0 : active_q);
  assign active_out = active_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      meta_q   <= 2'h0;
      sync_q   <= 2'h0;
      last_q   <= 2'h0;
      idle_q   <= 8'h00;
      fill_q   <= 3'h0;
      active_q <= 1'b0;
    end
    else if (ce_in)
    begin
      meta_q   <= {neg_in, pos_in};
      sync_q   <= meta_q;
      last_q   <= sync_q;
      idle_q   <= idle_d;
      fill_q   <= {fill_q[1:0], 1'b1};
      active_q <= active_d;
    end
  end
endmodule
`default_nettype wire

// ### tb/scrs_monitor.sv
// Checker bound to the strap decoder and reference selector
`timescale 1ns/1ps
`default_nettype none
module scrs_monitor (
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic        ce_in,
  input wire logic        manual_ref_pick_in,
  input wire logic        auto_sel_in,
  input wire logic        phase_err_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic        phase_lock_indicator_out,
  input wire logic [3:0]  odd_div_ratio_out,
  input wire logic        third_output_cml_out,
  input wire logic        cfg_done_out,
  input wire logic        ref_b_selected_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_done_timing: assert property ($rose(rst_n_in) |-> ##[55:70] cfg_done_out)
    else $error("config phase too long");
  a_done_sticky: assert property (cfg_done_out |=> cfg_done_out)
    else $error("config done dropped");
  a_div_odd: assert property (odd_div_ratio_out[0] && (cfg_done_out || odd_div_ratio_out == 4'h1))
    else $error("bad divide ratio");
  a_straps_hold: assert property (cfg_done_out |=> $stable(odd_div_ratio_out) && $stable(third_output_cml_out))
    else $error("decoded straps moved");
  a_lock_cause: assert property (phase_lock_indicator_out |-> cfg_done_out && ($past(phase_err_in, 2) || $past(phase_err_in, 3)))
    else $error("lock indicator without cause");
  a_manual_pick: assert property (((manual_ref_pick_in || !auto_sel_in) && ce_in && $stable(manual_ref_pick_in) && $stable(auto_sel_in))[*4] |-> ref_b_selected_out == manual_ref_pick_in)
    else $error("manual pick not followed");
  a_auto_settle: assert property ((auto_sel_in && !manual_ref_pick_in)[*4] ##1 $changed(ref_b_selected_out) |=> $stable(ref_b_selected_out)[*8])
    else $error("reference swapped twice");
  a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read cycle");
endmodule
bind scrs_top scrs_monitor scrs_monitor_i (.ref_clk_in, .rst_n_in, .ce_in, .manual_ref_pick_in,
  .auto_sel_in, .phase_err_in, .rd_in, .rdata_out, .phase_lock_indicator_out,
  .odd_div_ratio_out, .third_output_cml_out, .cfg_done_out, .ref_b_selected_out);
`default_nettype wire

// ### tb/scrs_board.sv
// Board model: strap wiring and the two reference oscillators
`timescale 1ns/1ps
`default_nettype none
module scrs_board (
  input  wire logic [3:0] cfg_pin_in,
  input  wire logic [2:0] six_code_in,
  input  wire logic [2:0] seven_code_in,
  input  wire logic       ref_a_on_in,
  input  wire logic       ref_b_on_in,
  output logic            strap_six_out,
  output logic            strap_seven_out,
  output logic            ref_a_pos_out,
  output logic            ref_a_neg_out,
  output logic            ref_b_pos_out,
  output logic            ref_b_neg_out
);
  // Code 0 ground, 1 power, 2..5 wired to config pin 0..3; others open, pull-down reads low
  function automatic logic level(input logic [2:0] c, input logic [3:0] p);
    if (c == 3'h0 || c > 3'h5)
      return 1'b0;
    if (c == 3'h1)
      return 1'b1;
    return p[c - 3'h2];
  endfunction
  assign strap_six_out   = level(six_code_in, cfg_pin_in);
  assign strap_seven_out = level(seven_code_in, cfg_pin_in);
  // A failed oscillator stands still; unrelated rates to the system clock
  initial ref_a_pos_out = 1'b0;
  initial ref_b_pos_out = 1'b0;
  always #37 if (ref_a_on_in) ref_a_pos_out = ~ref_a_pos_out;
  always #41 if (ref_b_on_in) ref_b_pos_out = ~ref_b_pos_out;
  assign ref_a_neg_out = ~ref_a_pos_out;
  assign ref_b_neg_out = ~ref_b_pos_out;
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the strap decoder and reference selector
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        pick = 1'b0, auto = 1'b0, perr = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        a_on = 1'b1, b_on = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, d;
  logic        irq, alarm, lock, cml3, cml4, done, ref_b, s6, s7, ap, an, bp, bn;
  logic [3:0]  pins, ratio;
  logic [2:0]  fcode;
  logic [2:0]  c6 = 3'h0, c7 = 3'h0;
  int          num_errors = 0;
  int          checked = 0;
  scrs_top scrs_top_i (.ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
    .strap_input_six_in(s6), .strap_input_seven_in(s7), .ref_a_pos_in(ap),
    .ref_a_neg_in(an), .ref_b_pos_in(bp), .ref_b_neg_in(bn), .manual_ref_pick_in(pick),
    .auto_sel_in(auto), .phase_err_in(perr), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq), .cfg_pin_out(pins),
    .selected_ref_alarm_out(alarm), .phase_lock_indicator_out(lock),
    .odd_div_ratio_out(ratio), .third_output_cml_out(cml3), .fourth_output_cml_out(cml4),
    .cfg_done_out(done), .ref_b_selected_out(ref_b), .ref_freq_code_out(fcode));
  scrs_board scrs_board_i (.cfg_pin_in(pins), .six_code_in(c6), .seven_code_in(c7),
    .ref_a_on_in(a_on), .ref_b_on_in(b_on), .strap_six_out(s6), .strap_seven_out(s7),
    .ref_a_pos_out(ap), .ref_a_neg_out(an), .ref_b_pos_out(bp), .ref_b_neg_out(bn));
  initial forever #25 clk = ~clk;
  task automatic close_out();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic t_config(input logic [2:0] k6, k7, input logic [3:0] er,
                          input logic el, ec, input logic [11:0] es);
    c6 <= k6;
    c7 <= k7;
    @(posedge clk);
    rst_n <= 1'b0;
    tick(5);
    rst_n <= 1'b1;
    for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge clk);
    tick(2);
    chk(12'(done), 12'h1);
    chk(12'(ratio), 12'(er));
    chk(12'(cml3), 12'(ec));
    chk(12'(cml4), 12'(ec));
    rd_reg(scrs_pkg::ADDR_STRAP_STAT);
    chk(d[11:0], es);
    c6 <= ~k6;
    perr <= 1'b1;
    tick(6);
    chk(12'(lock), 12'(el));
    chk(12'(ratio), 12'(er));
    perr <= 1'b0;
    tick(6);
    chk(12'(lock), 12'h0);
  endtask
  task automatic t_bus();
    wr_reg(scrs_pkg::ADDR_CTRL, 32'h5);
    rd_reg(scrs_pkg::ADDR_CTRL);
    chk(d[11:0], 12'h5);
    chk(12'(fcode), 12'h5);
    rd_reg(scrs_pkg::ADDR_IRQ_STAT);
    wr_reg(scrs_pkg::ADDR_CTRL, 32'h6);
    rd_reg(scrs_pkg::ADDR_CTRL);
    chk(d[11:0], 12'h5);
    rd_reg(scrs_pkg::ADDR_IRQ_STAT);
    chk(d[11:0], 12'h8);
    rd_reg(8'h14);
    chk(d[11:0], 12'h0);
    wr_reg(scrs_pkg::ADDR_IRQ_MASK, 32'hF);
    rd_reg(scrs_pkg::ADDR_IRQ_MASK);
    chk(d[11:0], 12'hF);
    chk(12'(irq), 12'h0);
  endtask
  task automatic t_manual();
    ce <= 1'b0;
    pick <= 1'b1;
    tick(5);
    chk(12'(ref_b), 12'h0);
    ce <= 1'b1;
    tick(5);
    chk(12'(ref_b), 12'h1);
    chk(12'(alarm), 12'h0);
    auto <= 1'b1;
    tick(5);
    chk(12'(ref_b), 12'h1);
    auto <= 1'b0;
    pick <= 1'b0;
    tick(5);
    chk(12'(ref_b), 12'h0);
  endtask
  task automatic t_auto();
    auto <= 1'b1;
    tick(5);
    chk(12'(ref_b), 12'h0);
    rd_reg(scrs_pkg::ADDR_IRQ_STAT);
    a_on <= 1'b0;
    for (int i = 0; i < 90 && ref_b !== 1'b1; i++) @(posedge clk);
    tick(3);
    chk(12'(ref_b), 12'h1);
    chk(12'(alarm), 12'h0);
    rd_reg(scrs_pkg::ADDR_IRQ_STAT);
    chk(12'(d[1]), 12'h1);
    wr_reg(scrs_pkg::ADDR_IRQ_MASK, 32'h4);
    b_on <= 1'b0;
    tick(70);
    chk(12'(ref_b), 12'h1);
    chk(12'(alarm), 12'h1);
    chk(12'(pins), 12'h8);
    chk(12'(irq), 12'h1);
    rd_reg(scrs_pkg::ADDR_REF_STAT);
    chk(d[11:0], 12'h013);
    rd_reg(scrs_pkg::ADDR_IRQ_STAT);
    chk(12'(d[2]), 12'h1);
    chk(12'(irq), 12'h0);
    a_on <= 1'b1;
    for (int i = 0; i < 90 && ref_b !== 1'b0; i++) @(posedge clk);
    tick(3);
    chk(12'(ref_b), 12'h0);
    chk(12'(alarm), 12'h0);
    b_on <= 1'b1;
    auto <= 1'b0;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial
  begin
    t_config(3'h3, 3'h4, 4'hD, 1'b1, 1'b1, 12'h8FE);
    t_bus();
    t_manual();
    t_auto();
    t_config(3'h1, 3'h2, 4'h1, 1'b0, 1'b0, 12'h460);
    close_out();
  end
endmodule
`default_nettype wire
